// ===== hw/sism_map.svh
// ============================================================================
// Constants of the safety input signal mapper: offsets, fields, codes, counts.
// Assumes inclusion by the mapper package, the mapper modules and the testbench only.
// ============================================================================
// Summary of operation
// - Sixteen mapping networks, each holding at most one mapper block and its setup.
// - Connector and inversion types have instance limits; exhausted types cannot be assigned again.
// - An inactive network (type zero) writes nothing to any target bit.
// - A connector copies its one safe input bit unchanged onto its target.
// - Connector may drive mode select, emergency stop, enabling control or motion selection bits.
// - Connector may drive the holding-system release bit of the brake control word.
// - Connector may drive door unlock request or door feedback bit of the door word.
// - At most sixteen connector and sixteen inversion instances exist.
// - Inversion drives its complemented input onto enabling control or motion selection bits.
// - One source bit may feed several networks at once without conflict.
// - Sources are safe inputs, local inputs, bus control, drive inputs, cam status.
// - Only safe sources may sit at safe inputs; functional sources are rejected.
// - With the predefined setup active, bus control bits link straight to fixed targets.
// - Mask bits remove bus bits from the predefined linkage, freeing their network.
// - Allowed target word and bit depend on block type; others are rejected.
// - Raise incorrect-configuration diagnostic on bad setup, mapper error on mapping faults.
`ifndef SISM_MAP_SVH
`define SISM_MAP_SVH

// Register byte offsets.
`define SISM_OFS_NET0       8'h00
`define SISM_OFS_CTRL       8'h40
`define SISM_OFS_MASK       8'h44
`define SISM_OFS_STATUS     8'h48
`define SISM_OFS_AVAIL      8'h4c
`define SISM_OFS_STATE_OUT  8'h50
`define SISM_OFS_AUX_OUT    8'h54

// Network configuration word fields.
`define SISM_TYPE_LSB       0
`define SISM_SRC_LSB        4
`define SISM_SBIT_LSB       8
`define SISM_TWORD_LSB      12
`define SISM_TBIT_LSB       16

// Control and status bit positions.
`define SISM_CTRL_RUN       0
`define SISM_CTRL_PREDEF    1
`define SISM_STAT_INCFG     0
`define SISM_STAT_MAPERR    1

// Block type codes.
`define SISM_TYPE_INACTIVE  3'h0
`define SISM_TYPE_CONNECTOR 3'h1
`define SISM_TYPE_INVERSION 3'h2

// Source word codes; null marks an unused input.
`define SISM_SRC_NULL       3'h0
`define SISM_SRC_SAFE_DI    3'h1
`define SISM_SRC_LOCAL_FI   3'h2
`define SISM_SRC_BUS_CW     3'h3
`define SISM_SRC_DRIVE_FI   3'h4
`define SISM_SRC_CAM        3'h5

// Target word codes.
`define SISM_TW_NONE        2'h0
`define SISM_TW_STATE       2'h1
`define SISM_TW_BRAKE       2'h2
`define SISM_TW_DOOR        2'h3

// Target bit positions and the flat target index space.
`define SISM_BIT_MODE       5'd0
`define SISM_BIT_ESTOP      5'd1
`define SISM_BIT_ENABLE     5'd2
`define SISM_BIT_MOTION_LO  5'd3
`define SISM_BIT_MOTION_HI  5'd18
`define SISM_BIT_DOOR_HI    5'd1
`define SISM_IDX_BRAKE      5'd19
`define SISM_IDX_DOOR0      5'd20
`define SISM_NUM_TARGETS    22
`define SISM_STATE_BITS     19

// Counts and reset values.
`define SISM_NUM_NETWORKS   16
`define SISM_MAX_CONNECTOR  16
`define SISM_MAX_INVERSION  16
`define SISM_RESET_CFG      32'h0000_0000
`define SISM_RESET_MASK     16'h0000
`define SISM_RESP_OKAY      2'h0
`define SISM_RESP_SLVERR    2'h2

`endif

// ===== hw/sism_pkg.sv
// ============================================================================
// Types shared by the safety input signal mapper modules.
// Assumes the constant header is on the include path.
// ============================================================================
`include "sism_map.svh"

package sism_pkg;

	// Mapper block types that the hardware evaluates.
	typedef enum logic [2:0] {
		SISM_BLK_INACTIVE  = `SISM_TYPE_INACTIVE,
		SISM_BLK_CONNECTOR = `SISM_TYPE_CONNECTOR,
		SISM_BLK_INVERSION = `SISM_TYPE_INVERSION
	} sism_block_t;

	// Flat index over every target bit of the three profile words.
	typedef logic [4:0] sism_tidx_t;

	// One source word of sixteen bits.
	typedef logic [15:0] sism_word_t;

endpackage

// ===== hw/sism_network.sv
// ============================================================================
// One mapping network: decodes its configuration word and evaluates its block.
// Assumes source words are already synchronous to the processing clock.
// ============================================================================
`timescale 1ns/1ns
`include "sism_map.svh"

module sism_network (
	// Configuration.
	input  wire logic [31:0]           cfg_word,
	// Source words.
	input  wire sism_pkg::sism_word_t  safe_di,
	input  wire sism_pkg::sism_word_t  local_fi,
	input  wire sism_pkg::sism_word_t  bus_cw,
	input  wire sism_pkg::sism_word_t  drive_fi,
	input  wire sism_pkg::sism_word_t  cam_status,
	// Evaluation result.
	output logic                       active,
	output logic                       cfg_ok,
	output sism_pkg::sism_tidx_t       tgt_idx,
	output logic                       value
);
	import sism_pkg::*;

	logic [2:0] blk_type;
	logic [2:0] src_id;
	logic [3:0] src_bit;
	logic [1:0] tword;
	logic [4:0] tbit;
	logic       src_val;
	logic       src_safe;
	logic       tgt_ok;

	// Field extraction.
	assign blk_type = cfg_word[`SISM_TYPE_LSB +: 3];
	assign src_id   = cfg_word[`SISM_SRC_LSB +: 3];
	assign src_bit  = cfg_word[`SISM_SBIT_LSB +: 4];
	assign tword    = cfg_word[`SISM_TWORD_LSB +: 2];
	assign tbit     = cfg_word[`SISM_TBIT_LSB +: 5];

	// Source selection; any bit of any word, shared freely with other networks.
	always_comb begin
		src_val  = 1'b0;
		src_safe = 1'b0;
		unique case (src_id)
			`SISM_SRC_SAFE_DI: begin
				src_val  = safe_di[src_bit];
				src_safe = 1'b1;
			end
			`SISM_SRC_BUS_CW: begin
				src_val  = bus_cw[src_bit];
				src_safe = 1'b1;
			end
			`SISM_SRC_CAM: begin
				src_val  = cam_status[src_bit];
				src_safe = 1'b1;
			end
			`SISM_SRC_LOCAL_FI: src_val = local_fi[src_bit];
			`SISM_SRC_DRIVE_FI: src_val = drive_fi[src_bit];
			default: src_val = 1'b0; // Null or unknown source is never safe.
		endcase
	end

	// Target legality per block type and the flat target index.
	always_comb begin
		tgt_ok  = 1'b0;
		tgt_idx = tbit;
		unique case (tword)
			`SISM_TW_STATE: begin
				if (blk_type == `SISM_TYPE_CONNECTOR)
					tgt_ok = (tbit <= `SISM_BIT_MOTION_HI);
				else
					tgt_ok = (tbit >= `SISM_BIT_ENABLE) && (tbit <= `SISM_BIT_MOTION_HI);
			end
			`SISM_TW_BRAKE: begin
				tgt_ok  = (blk_type == `SISM_TYPE_CONNECTOR) && (tbit == 5'd0);
				tgt_idx = `SISM_IDX_BRAKE;
			end
			`SISM_TW_DOOR: begin
				tgt_ok  = (blk_type == `SISM_TYPE_CONNECTOR) && (tbit <= `SISM_BIT_DOOR_HI);
				tgt_idx = `SISM_IDX_DOOR0 + tbit;
			end
			default: tgt_ok = 1'b0;
		endcase
	end

	// Block behaviour; an inactive block claims no target.
	assign active = (blk_type != `SISM_TYPE_INACTIVE);
	assign value  = (blk_type == `SISM_TYPE_INVERSION) ? ~src_val : src_val;
	assign cfg_ok = !active || ((blk_type == `SISM_TYPE_CONNECTOR
		|| blk_type == `SISM_TYPE_INVERSION) && src_safe && tgt_ok);
endmodule

// ===== hw/sism_mapper.sv
// ============================================================================
// Safety input signal mapper: sixteen networks, predefined bus linkage,
// diagnostics and an AXI4-Lite register slave.
// Assumes discrete input pins are asynchronous and all other inputs share aclk.
// ============================================================================
`timescale 1ns/1ns
`include "sism_map.svh"

module sism_mapper #(
	parameter int NUM_NETWORKS  = `SISM_NUM_NETWORKS,
	parameter int MAX_CONNECTOR = `SISM_MAX_CONNECTOR,
	parameter int MAX_INVERSION = `SISM_MAX_INVERSION,
	parameter int ADDR_W        = 8
) (
	// Clock, reset and freeze.
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// AXI4-Lite write address and data.
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	// AXI4-Lite write response.
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	// AXI4-Lite read.
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	// Source words.
	input  wire sism_pkg::sism_word_t safe_di_pins,
	input  wire sism_pkg::sism_word_t local_fi_pins,
	input  wire sism_pkg::sism_word_t bus_cw,
	input  wire sism_pkg::sism_word_t drive_fi,
	input  wire sism_pkg::sism_word_t safe_cam_status,
	// Processing cycle strobe.
	input  wire logic                cycle_tick,
	// Profile targets.
	output logic                     mode_select_signal,
	output logic                     emergency_stop_signal,
	output logic                     enabling_control_signal,
	output logic [15:0]              motion_selection_signal_n,
	output logic                     brake_release_request,
	output logic                     door_unlock_request,
	output logic                     door_feedback_signal,
	// Diagnostics.
	output logic                     incorrect_configuration_diag,
	output logic                     mapper_error_diag
);
	import sism_pkg::*;

	localparam int NT = `SISM_NUM_TARGETS;

	// ========================================================================
	// Elaboration checks
	// ========================================================================
	if (NUM_NETWORKS < 1 || NUM_NETWORKS > 16 || MAX_CONNECTOR > 31 || MAX_INVERSION > 31
		|| ADDR_W < 8) begin : g_bad_param
		$error("sism_mapper parameters out of range");
	end

	// ========================================================================
	// State
	// ========================================================================
	typedef struct packed {
		logic                         aw_got;
		logic                         w_got;
		logic [ADDR_W-1:0]            awaddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [1:0]                   rresp;
		logic [31:0]                  rdata;
		logic [NUM_NETWORKS-1:0][31:0] cfg;
		logic                         run;
		logic                         predef_en;
		logic [15:0]                  mask;
		logic                         incfg;
		logic                         mapper_err;
		logic [15:0]                  di_meta;
		logic [15:0]                  di_sync;
		logic [15:0]                  lf_meta;
		logic [15:0]                  lf_sync;
		logic [NT-1:0]                targets;
	} sism_state_t;

	sism_state_t s;
	sism_state_t next_s;

	logic [NUM_NETWORKS-1:0] net_active;
	logic [NUM_NETWORKS-1:0] net_ok;
	logic [NUM_NETWORKS-1:0] net_val;
	sism_tidx_t              net_idx [NUM_NETWORKS];
	logic [NT-1:0]           eval_targets;
	logic                    eval_bad;

	// ========================================================================
	// Functions
	// ========================================================================
	// Byte enable merge of a register word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// Network index of an address, or all ones when not a network register.
	function automatic logic [4:0] net_of(input logic [ADDR_W-1:0] a);
		logic [5:0] w;
		w = a[7:2];
		if ((a >> 8) == '0 && a[1:0] == 2'h0 && w < 6'(NUM_NETWORKS))
			return w[4:0];
		return 5'h1f;
	endfunction

	// Instances of one block type held by all networks except one.
	function automatic logic [4:0] count_type(input logic [NUM_NETWORKS-1:0][31:0] c,
		input logic [2:0] t, input logic [4:0] skip);
		logic [4:0] n;
		n = 5'd0;
		for (int i = 0; i < NUM_NETWORKS; i++) begin
			if (5'(i) != skip && c[i][`SISM_TYPE_LSB +: 3] == t)
				n = n + 5'd1;
		end
		return n;
	endfunction

	// Whether one more instance of a type may be allocated.
	function automatic logic type_free(input logic [NUM_NETWORKS-1:0][31:0] c,
		input logic [2:0] t, input logic [4:0] skip);
		if (t == `SISM_TYPE_CONNECTOR)
			return count_type(c, t, skip) < 5'(MAX_CONNECTOR);
		if (t == `SISM_TYPE_INVERSION)
			return count_type(c, t, skip) < 5'(MAX_INVERSION);
		return 1'b1;
	endfunction

	// ========================================================================
	// Networks
	// ========================================================================
	for (genvar g = 0; g < NUM_NETWORKS; g++) begin : g_net
		sism_network u_net (
			.cfg_word   (s.cfg[g]),
			.safe_di    (s.di_sync),
			.local_fi   (s.lf_sync),
			.bus_cw     (bus_cw),
			.drive_fi   (drive_fi),
			.cam_status (safe_cam_status),
			.active     (net_active[g]),
			.cfg_ok     (net_ok[g]),
			.tgt_idx    (net_idx[g]),
			.value      (net_val[g])
		);
	end

	// Combine predefined links and user networks into one target set.
	always_comb begin
		logic [NT-1:0] claimed;
		logic          linked;
		claimed      = '0;
		linked       = 1'b0;
		eval_targets = '0;
		eval_bad     = 1'b0;
		for (int i = 0; i < NUM_NETWORKS; i++) begin
			linked = s.predef_en && !s.mask[i];
			if (linked) begin
				claimed[i]      = 1'b1;
				eval_targets[i] = bus_cw[i];
			end
		end
		for (int i = 0; i < NUM_NETWORKS; i++) begin
			linked = s.predef_en && !s.mask[i];
			if (!linked && net_active[i]) begin
				if (!net_ok[i])
					eval_bad = 1'b1;
				else if (claimed[net_idx[i]])
					eval_bad = 1'b1;
				else begin
					claimed[net_idx[i]]      = 1'b1;
					eval_targets[net_idx[i]] = net_val[i];
				end
			end
		end
	end

	// ========================================================================
	// Next state
	// ========================================================================
	always_comb begin
		logic [4:0]  widx;
		logic [4:0]  ridx;
		logic [31:0] wv;
		logic [2:0]  ntype;
		next_s = s;
		widx   = net_of(s.awaddr);
		ridx   = net_of(araddr);
		wv     = 32'h0000_0000;
		ntype  = `SISM_TYPE_INACTIVE;

		// Pin synchronisers.
		next_s.di_meta = safe_di_pins;
		next_s.di_sync = s.di_meta;
		next_s.lf_meta = local_fi_pins;
		next_s.lf_sync = s.lf_meta;

		// Write address and data are taken independently.
		if (s.awready && awvalid) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (s.wready && wvalid) begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;

		// Register write once both halves are held.
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = `SISM_RESP_OKAY;
			if (widx != 5'h1f) begin
				wv    = merge(s.cfg[widx], s.wdata, s.wstrb);
				ntype = wv[`SISM_TYPE_LSB +: 3];
				if (type_free(s.cfg, ntype, widx))
					next_s.cfg[widx] = wv;
				else
					next_s.bresp = `SISM_RESP_SLVERR;
			end else begin
				unique case (s.awaddr)
					ADDR_W'(`SISM_OFS_CTRL): begin
						wv               = merge({30'h0, s.predef_en, s.run}, s.wdata, s.wstrb);
						next_s.run       = wv[`SISM_CTRL_RUN];
						next_s.predef_en = wv[`SISM_CTRL_PREDEF];
					end
					ADDR_W'(`SISM_OFS_MASK): begin
						wv          = merge({16'h0, s.mask}, s.wdata, s.wstrb);
						next_s.mask = wv[15:0];
					end
					ADDR_W'(`SISM_OFS_STATUS): begin
						if (s.wstrb[0] && s.wdata[`SISM_STAT_MAPERR])
							next_s.mapper_err = 1'b0;
					end
					ADDR_W'(`SISM_OFS_AVAIL), ADDR_W'(`SISM_OFS_STATE_OUT),
					ADDR_W'(`SISM_OFS_AUX_OUT): next_s.bresp = `SISM_RESP_OKAY;
					default: next_s.bresp = `SISM_RESP_SLVERR;
				endcase
			end
		end

		// Register read.
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (s.arready && arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = `SISM_RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			if (ridx != 5'h1f)
				next_s.rdata = s.cfg[ridx];
			else begin
				unique case (araddr)
					ADDR_W'(`SISM_OFS_CTRL):   next_s.rdata = {30'h0, s.predef_en, s.run};
					ADDR_W'(`SISM_OFS_MASK):   next_s.rdata = {16'h0, s.mask};
					ADDR_W'(`SISM_OFS_STATUS): next_s.rdata = {30'h0, s.mapper_err, s.incfg};
					ADDR_W'(`SISM_OFS_AVAIL):  next_s.rdata = {30'h0,
						type_free(s.cfg, `SISM_TYPE_INVERSION, 5'h1f),
						type_free(s.cfg, `SISM_TYPE_CONNECTOR, 5'h1f)};
					ADDR_W'(`SISM_OFS_STATE_OUT):
						next_s.rdata = {13'h0, s.targets[`SISM_STATE_BITS-1:0]};
					ADDR_W'(`SISM_OFS_AUX_OUT):
						next_s.rdata = {29'h0, s.targets[NT-1:`SISM_STATE_BITS]};
					default: next_s.rresp = `SISM_RESP_SLVERR;
				endcase
			end
		end

		// Diagnostics; a new fault wins over a clear in the same cycle.
		next_s.incfg = eval_bad;
		if (cycle_tick && s.run && eval_bad)
			next_s.mapper_err = 1'b1;

		// All targets change together, at each processing strobe while running; stopping clears them at once; faults fail safe.
		if (!s.run)
			next_s.targets = '0;
		else if (cycle_tick)
			next_s.targets = eval_bad ? '0 : eval_targets;

		// Ready signals follow the held state.
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// ========================================================================
	// Registers
	// ========================================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s            <= '0;
			s.cfg        <= {NUM_NETWORKS{`SISM_RESET_CFG}};
			s.mask       <= `SISM_RESET_MASK;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ========================================================================
	// Outputs
	// ========================================================================
	assign awready                      = s.awready;
	assign wready                       = s.wready;
	assign bvalid                       = s.bvalid;
	assign bresp                        = s.bresp;
	assign arready                      = s.arready;
	assign rvalid                       = s.rvalid;
	assign rresp                        = s.rresp;
	assign rdata                        = s.rdata;
	assign mode_select_signal           = s.targets[`SISM_BIT_MODE];
	assign emergency_stop_signal        = s.targets[`SISM_BIT_ESTOP];
	assign enabling_control_signal      = s.targets[`SISM_BIT_ENABLE];
	assign motion_selection_signal_n    = s.targets[`SISM_BIT_MOTION_HI:`SISM_BIT_MOTION_LO];
	assign brake_release_request        = s.targets[`SISM_IDX_BRAKE];
	assign door_unlock_request          = s.targets[`SISM_IDX_DOOR0];
	assign door_feedback_signal         = s.targets[`SISM_IDX_DOOR0 + 5'd1];
	assign incorrect_configuration_diag = s.incfg;
	assign mapper_error_diag            = s.mapper_err;
endmodule

// ===== testbench/sism_src_model.sv
// ==========
// Far-side model: safety input sources and the processing strobe.
// Assumes the bench hands it the next source words as one vector.
`timescale 1ns/1ns
module sism_src_model (
	// Clock, reset and requested words.
	input  wire logic [79:0]      w,
	input  wire logic             aclk, aresetn,
	// Source words and strobe.
	output sism_pkg::sism_word_t  safe_di = 16'h0, local_fi = 16'h0, bus_cw = 16'h0,
	output sism_pkg::sism_word_t  drive_fi = 16'h0, cam = 16'h0,
	output logic                  tick = 1'b0
);
	logic [1:0] ph = 2'h0;
	// Words move just after an edge; the strobe comes every fourth cycle.
	always @(posedge aclk) begin
		{cam, drive_fi, bus_cw, local_fi, safe_di} <= w;
		ph <= aresetn ? ph + 2'h1 : 2'h0;
		tick <= aresetn && ph == 2'h3;
	end
endmodule

// ===== testbench/sism_mapper_monitor.sv
// ==========
// Checker of bus answers, target timing and diagnostics.
// Assumes it is bound to the mapper top with ce held high.
`timescale 1ns/1ns
module sism_mapper_monitor (
	// Clock, reset and bus handshakes.
	input wire logic        aclk, aresetn, cycle_tick,
	input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
	input wire logic        arvalid, arready, rvalid, rready,
	input wire logic [1:0]  bresp,
	input wire logic [31:0] rdata,
	// Targets and diagnostics.
	input wire logic        mode_select_signal, emergency_stop_signal, enabling_control_signal,
	input wire logic        brake_release_request, door_unlock_request, door_feedback_signal,
	input wire logic [15:0] motion_selection_signal_n,
	input wire logic        incorrect_configuration_diag, mapper_error_diag
);
	// All target bits in flat index order.
	wire logic [21:0] tg = {door_feedback_signal, door_unlock_request, brake_release_request,
		motion_selection_signal_n, enabling_control_signal, emergency_stop_signal,
		mode_select_signal};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus answers hold until taken and come on time.
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_w_ans; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
	a_w_ans: assert property (p_w_ans) else $error("write answer not on time");
	property p_r_ans; arvalid && arready |=> rvalid; endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer not on time");
	property p_ar_busy; rvalid |-> !arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	// Targets move only at a strobe, or fall to zero.
	property p_tick; !cycle_tick |=> $stable(tg) || tg == 22'h0; endproperty
	a_tick: assert property (p_tick) else $error("targets moved off the strobe");
	// A bad setup seen at a strobe zeroes every target and latches the error.
	property p_err; $rose(mapper_error_diag) |->
		tg == 22'h0 && $past(cycle_tick) && incorrect_configuration_diag; endproperty
	a_err: assert property (p_err) else $error("error without zeroed targets");
	property p_stick; mapper_error_diag && awready |=> mapper_error_diag; endproperty
	a_stick: assert property (p_stick) else $error("error cleared without write");
	// Main scenarios.
	c_err: cover property ($rose(mapper_error_diag));
	c_slverr: cover property (bvalid && bresp == 2'h2);
	c_tg: cover property (cycle_tick ##1 tg != 22'h0);
endmodule

bind sism_mapper sism_mapper_monitor sism_mapper_monitor_i (.*);

// ===== testbench/sism_mapper_tb.sv
// ==========
// Self-checking bench of the mapper: random routing, refusals, linkage.
// Assumes the source model strobes every fourth cycle.
`timescale 1ns/1ns
`include "sism_map.svh"
module sism_mapper_tb;
	import sism_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, bready = 1'b1, rready = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, r, seed = 32'hfcf8c5e1;
	logic [31:0] bad [7];
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  bresp, rresp;
	logic [95:0] v, w = 96'h0;
	logic [21:0] e;
	logic [4:0]  t1;
	logic        awready, wready, bvalid, arready, rvalid, cycle_tick;
	logic        mode_select_signal, emergency_stop_signal, enabling_control_signal;
	logic        brake_release_request, door_unlock_request, door_feedback_signal;
	logic        incorrect_configuration_diag, mapper_error_diag;
	logic [15:0] motion_selection_signal_n;
	sism_word_t  safe_di_pins, local_fi_pins, bus_cw, drive_fi, safe_cam_status;
	int          n_mismatch = 0, comparisons = 0;
	wire  [21:0] tg = {door_feedback_signal, door_unlock_request, brake_release_request,
		motion_selection_signal_n, enabling_control_signal, emergency_stop_signal,
		mode_select_signal};
	always #4 aclk = ~aclk;
	sism_mapper #(.MAX_CONNECTOR(3)) sism_mapper_i (.*);
	sism_src_model sism_src_model_i (.w(w[79:0]), .aclk(aclk), .aresetn(aresetn),
		.safe_di(safe_di_pins), .local_fi(local_fi_pins), .bus_cw(bus_cw),
		.drive_fi(drive_fi), .cam(safe_cam_status), .tick(cycle_tick));
	// Random numbers and network setup words.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] cfg(input logic [2:0] t, s, input logic [3:0] b,
		input logic [1:0] tw, input logic [4:0] tb);
		return {11'h0, tb, 2'h0, tw, b, 1'b0, s, 1'b0, t};
	endfunction
	// Comparison, verdict and hang guard.
	task automatic chk(input logic [31:0] s, x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic to(input int i);
		if (i >= 20) begin
			n_mismatch++;
			summarize();
		end
	endtask
	// Bus cycles; each request is held until its ready is seen at an edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && ++i < 20);
		to(i);
		chk(bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
		int i = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && ++i < 20);
		to(i);
		chk(rdata, x);
		chk(rresp, er);
	endtask
	// Waits out two processing strobes, then one edge for the update to land.
	task automatic tk();
		int i;
		repeat (2) begin
			i = 0;
			do @(posedge aclk); while (!cycle_tick && ++i < 20);
			to(i);
		end
		@(posedge aclk);
	endtask
	// Main sequence.
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`SISM_OFS_AVAIL, 32'h3, 2'h0);
		rd(8'h60, 32'h0, 2'h2);
		wr(8'h41, 32'h1, 2'h2);
		for (int k = 0; k < 8; k++) begin
			v = {rnd(), rnd(), rnd()};
			r = rnd();
			t1 = 5'd2 + {1'b0, r[15:12]} + {4'h0, r[16]};
			w <= v;
			wr(8'h00, cfg(3'h1, 3'h3, r[3:0], 2'h1, {4'h0, r[4]}), 2'h0);
			wr(8'h04, cfg(3'h2, 3'h1, r[11:8], 2'h1, t1), 2'h0);
			wr(8'h08, cfg(3'h1, 3'h5, r[23:20], 2'h2, 5'h0), 2'h0);
			wr(8'h0c, cfg(3'h1, 3'h3, r[3:0], 2'h3, {4'h0, r[5]}), 2'h0);
			wr(`SISM_OFS_CTRL, 32'h1, 2'h0);
			tk();
			e = 22'h0;
			e[r[4]] = v[32 + r[3:0]];
			e[t1] = ~v[r[11:8]];
			e[19] = v[64 + r[23:20]];
			e[20 + r[5]] = v[32 + r[3:0]];
			chk(tg, e);
			rd(`SISM_OFS_STATE_OUT, e[18:0], 2'h0);
			rd(`SISM_OFS_AUX_OUT, {29'h0, e[21:19]}, 2'h0);
			chk(incorrect_configuration_diag, 1'b0);
		end
		wr(8'h10, cfg(3'h1, 3'h1, 4'h0, 2'h1, 5'h12), 2'h2);
		rd(`SISM_OFS_AVAIL, 32'h2, 2'h0);
		bad = '{cfg(3'h2, 3'h1, 4'h0, 2'h1, 5'h0), cfg(3'h1, 3'h2, 4'h0, 2'h3, 5'h1),
			cfg(3'h1, 3'h4, 4'h0, 2'h3, 5'h1), cfg(3'h3, 3'h1, 4'h0, 2'h3, 5'h1),
			cfg(3'h1, 3'h1, 4'h0, 2'h1, 5'h13), cfg(3'h1, 3'h0, 4'h0, 2'h3, 5'h1),
			cfg(3'h1, 3'h5, 4'h0, 2'h2, 5'h0)};
		foreach (bad[j]) begin
			wr(8'h0c, bad[j], 2'h0);
			tk();
			chk(incorrect_configuration_diag, 1'b1);
			chk({mapper_error_diag, tg}, 23'h400000);
		end
		for (int n = 0; n < 4; n++) wr(8'(4 * n), 32'h0, 2'h0);
		wr(`SISM_OFS_STATUS, 32'h2, 2'h0);
		tk();
		chk(tg, 22'h0);
		rd(`SISM_OFS_STATUS, 32'h0, 2'h0);
		for (int k = 0; k < 4; k++) begin
			v = {rnd(), rnd(), rnd()};
			w <= v;
			wr(`SISM_OFS_MASK, {16'h0, v[15:0]}, 2'h0);
			wr(`SISM_OFS_CTRL, 32'h3, 2'h0);
			tk();
			chk(tg, {6'h0, v[47:32] & ~v[15:0]});
		end
		summarize();
	end
endmodule
